// *** rtl/btm_matcher.sv ***
// design: event term comparator with wishbone registers and interrupt
`default_nettype none
module btm_matcher (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    // wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // observed target bus
    input  wire logic                     busSample,
    input  wire btm_pkg::btm_sample_t     busState,
    // to trigger sequencer
    output logic      [btm_pkg::TERMS-1:0] termMatch,
    output logic                          matchValid,
    output logic                          rangeTrigger,
    output logic                          breakHalt,
    output btm_pkg::btm_mode_t            activeMode,
    output logic                          irq
);
    import btm_pkg::*;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic isTermReg(input logic [7:0] adr,
                                       input logic [7:0] ofs,
                                       input int         t);
        return adr == 8'(TERM_STRIDE * t) + ofs;
    endfunction

    // ************************************************
    // register state
    // ************************************************
    logic      [31:0]       shValue [TERMS];
    logic      [31:0]       shCare  [TERMS];
    logic      [3:0]        shCtrl  [TERMS];
    btm_mode_t              shMode;
    btm_term_t              actTerm [TERMS];
    logic      [IRQ_W-1:0]  irqStat;
    logic      [IRQ_W-1:0]  irqMask;

    logic      [31:0]       next_shValue [TERMS];
    logic      [31:0]       next_shCare  [TERMS];
    logic      [3:0]        next_shCtrl  [TERMS];
    btm_mode_t              next_shMode;
    btm_term_t              next_actTerm [TERMS];
    btm_mode_t              next_activeMode;
    logic      [IRQ_W-1:0]  next_irqStat;
    logic      [IRQ_W-1:0]  next_irqMask;
    logic      [31:0]       next_wbDat;
    logic                   next_wbAck;

    logic                   wbWrite;
    logic                   wbRead;
    logic      [IRQ_W-1:0]  irqEvents;

    // single-cycle ack, no wait states beyond the registered answer
    assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign wbRead  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

    // ************************************************
    // match logic
    // ************************************************
    logic [WORD_W-1:0]  word;
    logic [TERMS-1:0]   patHit;
    logic [TERMS-1:0]   inRange;
    logic [TERMS-1:0]   isRangeEnd;
    logic [TERMS-1:0]   next_termMatch;
    logic               next_rangeTrigger;
    logic               next_breakHalt;

    // sample packs straight into the compare word, rw at msb
    assign word = WORD_W'(busState);

    generate
        for (genvar t = 0; t < TERMS; t++) begin : g_term
            // don't-care bits cleared in care mask drop out of compare
            assign patHit[t] = ((word ^ actTerm[t].value)
                                & actTerm[t].care) == '0;
            if (t == 0) begin : g_first
                // term A can only start a range
                assign isRangeEnd[t] = 1'b0;
                assign inRange[t]    = 1'b0;
            end else begin : g_rest
                // B-C is dropped when B already ends A-B, keeping pairs
                if (t == 2) begin : g_c
                    assign isRangeEnd[t] = actTerm[t].term_range_end
                                           & ~actTerm[1].term_range_end;
                end else begin : g_bd
                    assign isRangeEnd[t] = actTerm[t].term_range_end;
                end
                assign inRange[t] = (word >= actTerm[t-1].value)
                                    && (word <= actTerm[t].value);
            end
        end
    endgenerate

    always_comb begin
        logic base;
        base              = 1'b0;
        next_termMatch    = termMatch;
        next_rangeTrigger = rangeTrigger;
        next_breakHalt    = 1'b0;
        if (busSample) begin
            next_rangeTrigger = 1'b0;
            for (int t = 0; t < TERMS; t++) begin
                base = isRangeEnd[t] ? inRange[t] : patHit[t];
                next_termMatch[t] = actTerm[t].en
                                    & (base ^ actTerm[t].neg);
                if (isRangeEnd[t] && actTerm[t].en && inRange[t]) begin
                    next_rangeTrigger = 1'b1;
                end
                if (next_termMatch[t] && actTerm[t].brk) begin
                    next_breakHalt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            termMatch    <= '0;
            matchValid   <= 1'b0;
            rangeTrigger <= 1'b0;
            breakHalt    <= 1'b0;
        end else begin
            termMatch    <= next_termMatch;
            matchValid   <= busSample;
            rangeTrigger <= next_rangeTrigger;
            breakHalt    <= next_breakHalt;
        end
    end

    // ************************************************
    // interrupt events
    // ************************************************
    assign irqEvents[TERMS-1:0] = matchValid ? termMatch : '0;
    assign irqEvents[IRQ_BRK]   = breakHalt;

    // ************************************************
    // register file
    // ************************************************
    always_comb begin
        next_shValue    = shValue;
        next_shCare     = shCare;
        next_shCtrl     = shCtrl;
        next_shMode     = shMode;
        next_actTerm    = actTerm;
        next_activeMode = activeMode;
        next_irqMask    = irqMask;
        next_wbAck      = wbWrite | wbRead;
        next_wbDat      = wb_dat_o;
        // set wins over a write-one clear in the same cycle
        next_irqStat    = irqStat;
        if (wbWrite && wb_adr_i == OFS_IRQSTAT && wb_sel_i[0]) begin
            next_irqStat = irqStat & ~wb_dat_i[IRQ_W-1:0];
        end
        next_irqStat = next_irqStat | irqEvents;

        if (wbWrite) begin
            for (int t = 0; t < TERMS; t++) begin
                if (isTermReg(wb_adr_i, OFS_VALUE, t)) begin
                    next_shValue[t] = mergeBytes(shValue[t], wb_dat_i,
                                                 wb_sel_i);
                end
                if (isTermReg(wb_adr_i, OFS_CARE, t)) begin
                    next_shCare[t] = mergeBytes(shCare[t], wb_dat_i,
                                                wb_sel_i);
                end
                if (isTermReg(wb_adr_i, OFS_CTRL, t) && wb_sel_i[0]) begin
                    next_shCtrl[t] = wb_dat_i[3:0];
                end
            end
            if (wb_adr_i == OFS_MODE && wb_sel_i[0]) begin
                // out-of-range codes are refused, the old mode stays
                if (wb_dat_i[3:0] <= BTM_NTH) begin
                    next_shMode = btm_mode_t'(wb_dat_i[3:0]);
                end
            end
            if (wb_adr_i == OFS_IRQMASK && wb_sel_i[0]) begin
                next_irqMask = wb_dat_i[IRQ_W-1:0];
            end
            if (wb_adr_i == OFS_APPLY && wb_sel_i[0] && wb_dat_i[0]) begin
                // whole set moves at one edge so no cycle sees a mix
                for (int t = 0; t < TERMS; t++) begin
                    next_actTerm[t].value = shValue[t];
                    next_actTerm[t].care  = shCare[t];
                    next_actTerm[t].en    = shCtrl[t][CTRL_EN];
                    next_actTerm[t].brk   = shCtrl[t][CTRL_BRK];
                    next_actTerm[t].neg   = shCtrl[t][CTRL_NEG];
                    next_actTerm[t].term_range_end   = (t != 0)
                                            & shCtrl[t][CTRL_RNG];
                end
                next_activeMode = shMode;
            end
        end

        if (wbRead) begin
            next_wbDat = 32'h0000_0000;
            for (int t = 0; t < TERMS; t++) begin
                if (isTermReg(wb_adr_i, OFS_VALUE, t)) begin
                    next_wbDat = shValue[t];
                end
                if (isTermReg(wb_adr_i, OFS_CARE, t)) begin
                    next_wbDat = shCare[t];
                end
                if (isTermReg(wb_adr_i, OFS_CTRL, t)) begin
                    next_wbDat = {28'h000_0000, shCtrl[t]};
                end
            end
            case (wb_adr_i)
                OFS_MODE: begin
                    next_wbDat = {24'h00_0000, activeMode, shMode};
                end
                OFS_IRQSTAT: begin
                    next_wbDat = {27'h000_0000, irqStat};
                end
                OFS_IRQMASK: begin
                    next_wbDat = {27'h000_0000, irqMask};
                end
                OFS_LIVE: begin
                    next_wbDat = {25'h000_0000, breakHalt, rangeTrigger,
                                  matchValid, termMatch};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int t = 0; t < TERMS; t++) begin
                shValue[t] <= RST_VALUE;
                shCare[t]  <= RST_CARE;
                shCtrl[t]  <= RST_CTRL;
                actTerm[t] <= '0;
            end
            shMode     <= BTM_CONT_ALL;
            activeMode <= BTM_CONT_ALL;
            irqStat    <= '0;
            irqMask    <= '0;
            wb_dat_o   <= 32'h0000_0000;
            wb_ack_o   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            shValue    <= next_shValue;
            shCare     <= next_shCare;
            shCtrl     <= next_shCtrl;
            actTerm    <= next_actTerm;
            shMode     <= next_shMode;
            activeMode <= next_activeMode;
            irqStat    <= next_irqStat;
            irqMask    <= next_irqMask;
            wb_dat_o   <= next_wbDat;
            wb_ack_o   <= next_wbAck;
            irq        <= |(next_irqStat & next_irqMask);
        end
    end
endmodule
`default_nettype wire

// *** rtl/btm_pkg.sv ***
// package: layout, offsets and types of the bus event trigger matcher
`default_nettype none
package btm_pkg;
    // ************************************************
    // compare word layout
    // ************************************************
    localparam int TERMS     = 4;
    localparam int WORD_W    = 32;
    localparam int CLIPS     = 5;
    localparam int ADDR_W    = 17;
    localparam int DATA_W    = 8;
    localparam int RW_POS    = 31;
    localparam int DI_POS    = 30;
    localparam int CLIP_LSB  = 25;
    localparam int ADDR_LSB  = 8;
    localparam int DATA_LSB  = 0;

    // ************************************************
    // register offsets (byte addresses)
    // ************************************************
    localparam logic [7:0] TERM_STRIDE  = 8'h10;
    localparam logic [7:0] OFS_VALUE    = 8'h00;
    localparam logic [7:0] OFS_CARE     = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_MODE     = 8'h40;
    localparam logic [7:0] OFS_APPLY    = 8'h44;
    localparam logic [7:0] OFS_IRQSTAT  = 8'h48;
    localparam logic [7:0] OFS_IRQMASK  = 8'h4c;
    localparam logic [7:0] OFS_LIVE     = 8'h50;

    // ctrl field positions, irq status width and break bit
    localparam int CTRL_EN   = 0;
    localparam int CTRL_BRK  = 1;
    localparam int CTRL_NEG  = 2;
    localparam int CTRL_RNG  = 3;
    localparam int IRQ_W     = 5;
    localparam int IRQ_BRK   = 4;

    // reset values
    localparam logic [31:0] RST_VALUE = 32'h0000_0000;
    localparam logic [31:0] RST_CARE  = 32'h0000_0000;
    localparam logic [3:0]  RST_CTRL  = 4'h0;

    typedef enum logic [3:0] {
        BTM_CONT_ALL   = 4'h0,
        BTM_CONT_EVT   = 4'h1,
        BTM_CNT_ALL    = 4'h2,
        BTM_CNT_EVT    = 4'h3,
        BTM_ANY        = 4'h4,
        BTM_AB_THEN_CD = 4'h5,
        BTM_ABC_NOT_D  = 4'h6,
        BTM_ABCD       = 4'h7,
        BTM_NTH        = 4'h8
    } btm_mode_t;

    typedef struct packed {
        logic              rw;
        logic              di;
        logic [CLIPS-1:0]  clip;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } btm_sample_t;

    typedef struct packed {
        logic              term_range_end;
        logic              neg;
        logic              brk;
        logic              en;
        logic [WORD_W-1:0] value;
        logic [WORD_W-1:0] care;
    } btm_term_t;
endpackage
`default_nettype wire

// *** verif/btm_matcher_assertions.sv ***
// checker: port timing relations of the event term matcher
`default_nettype none
module btm_matcher_assertions (
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      reset_n,
    // wishbone
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic                      wb_ack_o,
    // match path
    input wire logic                      busSample,
    input wire logic [btm_pkg::TERMS-1:0] termMatch,
    input wire logic                      matchValid,
    input wire logic                      rangeTrigger,
    input wire logic                      breakHalt,
    input wire btm_pkg::btm_mode_t        activeMode
);
    timeunit 1ns;
    timeprecision 1ns;
    import btm_pkg::*;
    // ************************************************
    // properties
    // ************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence wbTake;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence freshMatch;
        matchValid && $past(busSample);
    endsequence
    chk_ack_answer: assert property (
        wbTake |=> wb_ack_o) else $error("ack missing after request");
    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_sample_latency: assert property (
        busSample |=> matchValid) else $error("no result after sample");
    chk_valid_cause: assert property (
        matchValid |-> $past(busSample)) else $error("result without sample");
    chk_match_hold: assert property (
        !busSample |=> $stable(termMatch) && $stable(rangeTrigger))
        else $error("match changed without sample");
    chk_halt_match: assert property (
        breakHalt |-> freshMatch and termMatch != 4'h0)
        else $error("halt without term match");
    chk_range_fresh: assert property (
        $changed(rangeTrigger) |-> freshMatch)
        else $error("range trigger moved off a sample");
    chk_mode_apply: assert property (
        $changed(activeMode) |-> wb_ack_o && wb_we_i)
        else $error("mode changed without host write");
    chk_mode_legal: assert property (
        activeMode <= BTM_NTH) else $error("mode outside nine");
endmodule
bind btm_matcher btm_matcher_assertions chk_u (
    .mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .busSample, .termMatch, .matchValid, .rangeTrigger, .breakHalt,
    .activeMode
);
`default_nettype wire

// *** verif/btm_target_bus.sv ***
// partner: target processor bus issuing sampled cycles
`default_nettype none
module btm_target_bus (
    // clock
    input  wire logic          mclk,
    // sampled bus
    output var  logic          busSample,
    output btm_pkg::btm_sample_t busState
);
    timeunit 1ns;
    timeprecision 1ns;
    import btm_pkg::*;
    initial begin
        busSample = 1'b0;
        busState = '0;
    end
    // bus keeps moving between samples so stale values never match
    task automatic idleCycles(input int n);
        repeat (n) begin
            busSample <= 1'b0;
            busState <= ~busState;
            @(posedge mclk);
        end
    endtask
    task automatic sendCycle(input logic [31:0] w, input int gap);
        idleCycles(gap);
        busSample <= 1'b1;
        busState <= w;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: random term setups and bus cycles against a model
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import btm_pkg::*;
    logic        mclk, reset_n, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0]  wbAdr;
    logic [31:0] wbDat, wbRdat, rd;
    logic        busSample, matchValid, rangeTrigger, breakHalt, irq;
    btm_sample_t busState;
    logic [3:0]  termMatch;
    btm_mode_t   activeMode;
    logic [31:0] aVal [4], aCare [4], pVal [4], pCare [4];
    logic [3:0]  aCtl [4], pCtl [4];
    logic [3:0]  rngTab [6] = '{4'h2, 4'h4, 4'h8, 4'ha, 4'h6, 4'h0};
    logic [5:0]  expQ [$];
    logic [5:0]  expW;
    logic [4:0]  statModel, mask;
    int          badCount, numChecks, aMode;
    btm_matcher dut_u (
        .mclk, .reset_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
        .wb_dat_i(wbDat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
        .busSample, .busState, .termMatch, .matchValid,
        .rangeTrigger, .breakHalt, .activeMode, .irq
    );
    btm_target_bus busU (.mclk, .busSample, .busState);
    always #25 mclk = ~mclk;
    // ************************************************
    // tasks
    // ************************************************
    task automatic chkWord(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wbXfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= dat;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        rd = wbRdat;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge mclk);
    endtask
    // reference: pattern or range hit, then enable, negation, breakpoint
    function automatic logic [5:0] predict(input logic [31:0] w);
        logic [3:0] m;
        logic       r, b, hit, rg;
        m = 4'h0;
        r = 1'b0;
        b = 1'b0;
        for (int t = 0; t < 4; t++) begin
            rg = t > 0 && aCtl[t][3] && !(t == 2 && aCtl[1][3]);
            hit = ((w ^ aVal[t]) & aCare[t]) == 32'h0;
            if (rg) hit = w >= aVal[(t + 3) % 4] && w <= aVal[t];
            if (aCtl[t][0]) begin
                r |= rg & hit;
                m[t] = hit ^ aCtl[t][2];
                b |= m[t] & aCtl[t][1];
            end
        end
        return {b, r, m};
    endfunction
    task automatic runSamples(input int n);
        logic [31:0] w;
        int          k;
        repeat (n) begin
            k = $urandom_range(3);
            w = $urandom;
            if ($urandom_range(1) == 1) w = aVal[k] ^ ($urandom & ~aCare[k]);
            expQ.push_back(predict(w));
            busU.sendCycle(w, $urandom_range(2));
        end
        busU.idleCycles(2);
    endtask
    always @(posedge mclk) begin
        if (matchValid === 1'b1) begin
            expW = 'x;
            if (expQ.size() > 0) expW = expQ.pop_front();
            chkWord("match", 32'(expW),
                {26'h0, breakHalt, rangeTrigger, termMatch});
            statModel |= {expW[5], expW[3:0]};
        end
    end
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} = '0;
        {badCount, numChecks, aMode, statModel} = '0;
        for (int t = 0; t < 4; t++) begin
            {aVal[t], aCare[t], aCtl[t]} = '0;
        end
        void'($urandom(32'h8cb0));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        wbXfer(1'b0, OFS_CTRL, 32'h0);
        chkWord("ctrl reset", 32'h0, rd);
        wbXfer(1'b0, 8'h7c, 32'h0);
        chkWord("unmapped read", 32'h0, rd);
        for (int r = 0; r < 9; r++) begin
            for (int t = 0; t < 4; t++) begin
                pVal[t] = $urandom;
                pCare[t] = $urandom;
                pCtl[t] = {rngTab[r % 6][t], 2'($urandom), (t + r) % 4 != 3};
                wbXfer(1'b1, TERM_STRIDE * 8'(t) + OFS_VALUE, pVal[t]);
                wbXfer(1'b1, TERM_STRIDE * 8'(t) + OFS_CARE, pCare[t]);
                wbXfer(1'b1, TERM_STRIDE * 8'(t) + OFS_CTRL, 32'(pCtl[t]));
            end
            wbXfer(1'b1, OFS_MODE, 32'(r));
            wbXfer(1'b1, OFS_MODE, 32'h9);
            wbXfer(1'b0, OFS_MODE, 32'h0);
            chkWord("mode", 32'({4'(aMode), 4'(r)}), rd);
            runSamples(4);
            wbXfer(1'b1, OFS_APPLY, 32'h1);
            aVal = pVal;
            aCare = pCare;
            aCtl = pCtl;
            aMode = r;
            chkWord("active mode", 32'(r), 32'(activeMode));
            wbXfer(1'b0, TERM_STRIDE * 8'(r % 4) + OFS_VALUE, 32'h0);
            chkWord("value", pVal[r % 4], rd);
            mask = (r % 2 == 1) ? 5'h10 : 5'h1f;
            wbXfer(1'b1, OFS_IRQMASK, 32'(mask));
            runSamples(40);
            wbXfer(1'b0, OFS_IRQSTAT, 32'h0);
            chkWord("irq status", 32'(statModel), rd);
            wbXfer(1'b0, OFS_LIVE, 32'h0);
            chkWord("live", 32'({1'b0, expW[4], 1'b0, expW[3:0]}), rd);
            chkWord("irq", 32'(|(statModel & mask)), 32'(irq));
            wbXfer(1'b1, OFS_IRQSTAT, 32'h1f);
            statModel = '0;
            busU.idleCycles(2);
            chkWord("irq cleared", 32'h0, 32'(irq));
        end
        completeRun();
    end
    initial begin
        #2000000;
        badCount++;
        completeRun();
    end
endmodule
`default_nettype wire
